// *** verification/usb_ep_ctrl_tb_top.sv ***
// Self-checking bench for the endpoint control block.
// Assumes the host model above and the design package are compiled first.
`timescale 1ns/1ps

module usb_ep_ctrl_tb_top
    import usb_ep_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic tok_v;
    logic [1:0] tok_t;
    logic [7:0] tok_ep;
    logic setup_f;
    logic hs_v;
    logic [1:0] hs_c;
    logic rx_w;
    logic tx_s;
    logic single;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    usb_host_token_model i_usb_host_token_model (.i_clk_sys(clk), .o_token_valid(tok_v),
        .o_token_type(tok_t), .o_token_ep(tok_ep), .o_setup_received(setup_f));

    usb_ep_ctrl i_usb_ep_ctrl (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_token_valid(tok_v),
        .i_token_type(tok_t), .i_token_ep(tok_ep), .i_setup_received(setup_f),
        .o_hs_valid(hs_v), .o_hs_code(hs_c), .o_rx_write(rx_w), .o_tx_send(tx_s),
        .o_rx_single_packet(single));

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    // Write and read back with no idle cycle, so the read sees a forwarded value.
    task automatic wr_rd_check(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check8(rdata, exp);
        @(posedge clk);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check8(rdata, exp);
        @(posedge clk);
    endtask

    // Expected outputs are packed as valid, code, receive write, transmit send.
    task automatic tok(input logic [1:0] t, input logic [7:0] ep, input logic s,
                       input logic [1:0] code);
        logic [7:0] exp;
        exp = {3'h0, 1'b1, code, code == HS_DATA && t != TOK_IN, code == HS_DATA && t == TOK_IN};
        i_usb_host_token_model.send(t, ep, s);
        @(posedge clk);
        #1;
        check8({3'h0, hs_v, hs_c, rx_w, tx_s}, exp);
        @(posedge clk);
    endtask

    task automatic t_reset_values();
        rd_check(`EPIDX_ADDR, 8'h00);
        rd_check(`EPCTL_ADDR, 8'h35);
        for (int i = 1; i < 4; i++) begin
            wr(`EPIDX_ADDR, 8'(i));
            rd_check(`EPCTL_ADDR, 8'h10);
        end
        rd_check(8'h00, 8'h00);
    endtask

    task automatic t_ep0_default();
        tok(TOK_OUT, 8'h00, 1'b0, HS_NAK);
        tok(TOK_IN, 8'h00, 1'b0, HS_NAK);
        tok(TOK_SETUP, 8'h00, 1'b0, HS_DATA);
        check8({7'h0, single}, 8'h01);
        rd_check(`HSSTAT_ADDR, 8'h01);
    endtask

    task automatic t_disabled();
        tok(TOK_OUT, 8'h01, 1'b0, HS_SILENT);
        tok(TOK_SETUP, 8'h01, 1'b0, HS_SILENT);
        tok(TOK_IN, 8'h01, 1'b0, HS_SILENT);
    endtask

    task automatic t_rx_stall();
        wr(`EPIDX_ADDR, 8'h01);
        wr_rd_check(`EPCTL_ADDR, 8'h8f, 8'h8f);
        tok(TOK_OUT, 8'h01, 1'b0, HS_STALL);
        tok(TOK_OUT, 8'h01, 1'b1, HS_NAK);
        tok(TOK_SETUP, 8'h01, 1'b0, HS_SILENT);
        tok(TOK_IN, 8'h01, 1'b0, HS_DATA);
        check8({7'h0, single}, 8'h00);
    endtask

    task automatic t_tx_stall();
        wr(`EPIDX_ADDR, 8'h02);
        wr(`EPCTL_ADDR, 8'h7f);
        tok(TOK_IN, 8'h02, 1'b0, HS_STALL);
        tok(TOK_IN, 8'h02, 1'b1, HS_NAK);
        tok(TOK_OUT, 8'h02, 1'b0, HS_DATA);
        tok(TOK_SETUP, 8'h02, 1'b0, HS_DATA);
        check8({7'h0, single}, 8'h01);
    endtask

    task automatic t_setup_override();
        wr(`EPIDX_ADDR, 8'h03);
        wr(`EPCTL_ADDR, 8'ha4);
        tok(TOK_SETUP, 8'h03, 1'b0, HS_DATA);
        tok(TOK_OUT, 8'h03, 1'b0, HS_STALL);
        wr(`EPCTL_ADDR, 8'ha0);
        tok(TOK_SETUP, 8'h03, 1'b0, HS_SILENT);
    endtask

    task automatic t_hub();
        wr(`EPIDX_ADDR, 8'h80);
        rd_check(`EPCTL_ADDR, 8'h30);
        wr(`EPCTL_ADDR, 8'h04);
        rd_check(`EPCTL_ADDR, 8'h34);
        tok(TOK_SETUP, 8'h80, 1'b0, HS_DATA);
        wr_rd_check(`EPCTL_ADDR, 8'h00, 8'h30);
        tok(TOK_OUT, 8'h05, 1'b0, HS_SILENT);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("Error at %0t: run did not finish in time", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_ep0_default();
        t_disabled();
        t_rx_stall();
        t_tx_stall();
        t_setup_override();
        t_hub();
        tally_and_finish();
    end
endmodule // usb_ep_ctrl_tb_top

// *** verification/usb_host_token_model.sv ***
// Host side of the serial bus: issues one token a cycle to the endpoint logic.
// Assumes the caller enters send just after a rising edge of i_clk_sys.
`timescale 1ns/1ps

module usb_host_token_model
    import usb_ep_pkg::*;
(
    input wire logic i_clk_sys,
    output logic o_token_valid,
    output logic [1:0] o_token_type,
    output logic [7:0] o_token_ep,
    output logic o_setup_received
);
    initial begin
        o_token_valid = 1'b0;
        o_token_type = TOK_NONE;
        o_token_ep = 8'h00;
        o_setup_received = 1'b0;
    end

    // The setup flag is a level from the receive path, so it stays put between tokens.
    task automatic send(input logic [1:0] t, input logic [7:0] ep, input logic s);
        o_token_valid <= 1'b1;
        o_token_type <= t;
        o_token_ep <= ep;
        o_setup_received <= s;
        @(posedge i_clk_sys);
        o_token_valid <= 1'b0;
        o_token_type <= TOK_NONE;
        // The endpoint field is stale once the token is gone, so it is scrambled.
        o_token_ep <= ~ep;
    endtask
endmodule // usb_host_token_model

// *** verilog/ep_ctrl_mem.sv ***
// Per-endpoint control table with two registered read ports.
// Assumes one writer; a write forwards to a read of the same entry.
`timescale 1ns/1ps

module ep_ctrl_mem
    import usb_ep_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    ep_mem_if.mem mif
);

    logic [7:0] entry_reg [0:`EP_ENTRIES-1];

    for (genvar e = 0; e < `EP_ENTRIES; e++) begin : g_entry
        localparam logic [2:0] SEL = 3'(e);
        localparam logic [7:0] RST = (SEL == 3'h0) ? `EP0_RST :
                                     (SEL == `HUB_ENTRY) ? `HUB_RST : `EPN_RST;
        always_ff @(posedge i_clk_sys) begin
            if (!i_rstn) begin
                entry_reg[e] <= RST; // RQ2
            end else if (mif.wr_en && mif.wr_sel == SEL) begin
                entry_reg[e] <= mif.wr_data;
            end
        end
    end

    // Forwarding keeps a read in the cycle after a write from seeing stale data.
    function automatic logic [7:0] look(input logic [2:0] sel);
        logic [7:0] v;
        v = 8'h00;
        if (mif.wr_en && mif.wr_sel == sel) begin
            v = mif.wr_data;
        end else if (sel < 3'(`EP_ENTRIES)) begin
            v = entry_reg[sel];
        end
        return v;
    endfunction

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            mif.cpu_q <= `EP0_RST;
        end else begin
            mif.cpu_q <= look(mif.cpu_sel);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            mif.tok_q <= 8'h00;
        end else begin
            mif.tok_q <= look(mif.tok_sel);
        end
    end

endmodule // ep_ctrl_mem

// *** verilog/ep_mem_if.sv ***
// Connection between the endpoint control logic and its entry table.
// Both sides run on the same system clock.
`timescale 1ns/1ps

interface ep_mem_if;
    logic wr_en;
    logic [2:0] wr_sel;
    logic [7:0] wr_data;
    logic [2:0] cpu_sel;
    logic [7:0] cpu_q;
    logic [2:0] tok_sel;
    logic [7:0] tok_q;

    modport ctrl (
        output wr_en, wr_sel, wr_data, cpu_sel, tok_sel,
        input cpu_q, tok_q
    );
    modport mem (
        input wr_en, wr_sel, wr_data, cpu_sel, tok_sel,
        output cpu_q, tok_q
    );
endinterface

// *** verilog/usb_ep_ctrl.sv ***
// Endpoint control and handshake decision for a USB function.
// Assumes tokens and the setup-received level come from logic on i_clk_sys.
// Notes on behaviour
// RQ1: One indexed control register at one address.
// RQ2: Reset loads 0x35 for endpoint 0, 0x10 others; the code loads 0x30 into the hub entry.
// RQ3: Receive stall: STALL OUT, NAK if setup pending.
// RQ4: Receive stall never blocks SETUP on control endpoints.
// RQ5: Transmit stall: STALL IN, NAK if setup pending.
// RQ6: Only control endpoints accept SETUP tokens.
// RQ7: Single-packet bit limits receive FIFO to one packet.
// RQ8: Firmware should use single-packet mode for control endpoints.
// RQ9: Input disabled: drop OUT data, answer NAK.
// RQ10: Valid SETUP overrides input disable, data stored.
// RQ11: Hub endpoint control and single-packet bits fixed one.
// RQ12: Receive endpoint disabled: silent to OUT and SETUP.
// RQ13: Output disabled, no stall: NAK the IN token.
// RQ14: Transmit endpoint disabled: silent to IN.
// RQ15: Setup-received flag is a receive-path status input.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

module usb_ep_ctrl
    import usb_ep_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_token_valid,
    input wire logic [1:0] i_token_type,
    input wire logic [7:0] i_token_ep,
    input wire logic i_setup_received,
    output logic o_hs_valid,
    output logic [1:0] o_hs_code,
    output logic o_rx_write,
    output logic o_tx_send,
    output logic o_rx_single_packet
);

    ep_mem_if mif ();

    ep_ctrl_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .mif(mif.mem)
    );

    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic [2:0] idx_sel;
    logic tok_v_reg;
    logic tok_ok_reg;
    token_t tok_type_reg;
    logic setup_reg;
    hs_t last_hs_reg;
    hs_t hs_next;
    logic rx_write_next;
    logic tx_send_next;
    logic [7:0] ctl;

    assign idx_next = (i_wr && i_addr == `EPIDX_ADDR) ? i_wdata : idx_reg;
    assign idx_sel = entry_of(idx_reg);
    assign ctl = mif.tok_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            idx_reg <= `EPIDX_RST;
        end else begin
            idx_reg <= idx_next;
        end
    end

    // Writes land in the entry picked by the index; an unknown index drops them.
    assign mif.wr_en = i_wr && i_addr == `EPCTL_ADDR && idx_sel != `NO_ENTRY; // RQ1
    assign mif.wr_sel = idx_sel;
    assign mif.wr_data = (idx_sel == `HUB_ENTRY) ? (i_wdata | `HUB_FIXED_MASK)
                                                 : i_wdata; // RQ11
    assign mif.cpu_sel = entry_of(idx_next);
    assign mif.tok_sel = entry_of(i_token_ep);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd && i_addr == `EPCTL_ADDR) begin
            o_rdata <= mif.cpu_q; // RQ1
        end else if (i_rd && i_addr == `EPIDX_ADDR) begin
            o_rdata <= idx_reg;
        end else if (i_rd && i_addr == `HSSTAT_ADDR) begin
            o_rdata <= {6'h00, last_hs_reg};
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // The table read takes one cycle, so the token is held beside it.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            tok_v_reg <= 1'b0;
            tok_ok_reg <= 1'b0;
            tok_type_reg <= TOK_NONE;
            setup_reg <= 1'b0;
        end else begin
            tok_v_reg <= i_token_valid;
            tok_ok_reg <= entry_of(i_token_ep) != `NO_ENTRY;
            tok_type_reg <= token_t'(i_token_type);
            setup_reg <= i_setup_received; // RQ15
        end
    end

    always_comb begin
        hs_next = HS_SILENT;
        rx_write_next = 1'b0;
        tx_send_next = 1'b0;
        if (tok_ok_reg) begin
            case (tok_type_reg)
                TOK_OUT: begin
                    if (!ctl[`BIT_RX_EP_EN]) begin
                        hs_next = HS_SILENT; // RQ12
                    end else if (ctl[`BIT_RX_STALL]) begin
                        hs_next = setup_reg ? HS_NAK : HS_STALL; // RQ3
                    end else if (!ctl[`BIT_RX_IN_EN]) begin
                        hs_next = HS_NAK; // RQ9
                    end else begin
                        hs_next = HS_DATA;
                        rx_write_next = 1'b1;
                    end
                end
                TOK_SETUP: begin
                    // Stall and input enable are ignored here on purpose.
                    if (ctl[`BIT_RX_EP_EN] && ctl[`BIT_CTL_EP]) begin // RQ6 RQ12
                        hs_next = HS_DATA; // RQ4
                        rx_write_next = 1'b1; // RQ10
                    end
                end
                TOK_IN: begin
                    if (!ctl[`BIT_TX_EP_EN]) begin
                        hs_next = HS_SILENT; // RQ14
                    end else if (ctl[`BIT_TX_STALL]) begin
                        hs_next = setup_reg ? HS_NAK : HS_STALL; // RQ5
                    end else if (!ctl[`BIT_TX_OUT_EN]) begin
                        hs_next = HS_NAK; // RQ13
                    end else begin
                        hs_next = HS_DATA;
                        tx_send_next = 1'b1;
                    end
                end
                default: begin
                    hs_next = HS_SILENT;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_hs_valid <= 1'b0;
            o_hs_code <= HS_SILENT;
            o_rx_write <= 1'b0;
            o_tx_send <= 1'b0;
        end else begin
            o_hs_valid <= tok_v_reg;
            o_hs_code <= tok_v_reg ? hs_next : HS_SILENT;
            o_rx_write <= tok_v_reg && rx_write_next;
            o_tx_send <= tok_v_reg && tx_send_next;
        end
    end

    // The receive FIFO follows this level to allow one packet or two.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rx_single_packet <= 1'b0;
        end else if (tok_v_reg && tok_ok_reg) begin
            o_rx_single_packet <= ctl[`BIT_RX_SINGLE]; // RQ7
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            last_hs_reg <= HS_SILENT;
        end else if (tok_v_reg) begin
            last_hs_reg <= hs_next;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence s_tok(token_t t);
        tok_v_reg && tok_ok_reg && tok_type_reg == t;
    endsequence

    property p_rq1;
        (mif.wr_en && idx_sel != `HUB_ENTRY) ##1 (i_rd && i_addr == `EPCTL_ADDR)
            |=> o_rdata == $past(i_wdata, 2);
    endproperty
    a_rq1: assert property (p_rq1) else $error("control readback mismatch"); // RQ1

    property p_rq2;
        $past(!i_rstn) |-> mif.cpu_q == `EP0_RST && idx_reg == `EPIDX_RST;
    endproperty
    a_rq2: assert property (p_rq2) else $error("endpoint 0 reset value wrong"); // RQ2

    property p_rq3;
        s_tok(TOK_OUT) and (ctl[`BIT_RX_EP_EN] && ctl[`BIT_RX_STALL])
            |=> o_hs_valid && o_hs_code == ($past(setup_reg) ? HS_NAK : HS_STALL);
    endproperty
    a_rq3: assert property (p_rq3) else $error("receive stall answer wrong"); // RQ3

    property p_rq4;
        s_tok(TOK_SETUP) and (ctl[`BIT_RX_EP_EN] && ctl[`BIT_CTL_EP])
            |=> o_hs_code == HS_DATA && o_rx_write;
    endproperty
    a_rq4: assert property (p_rq4) else $error("setup not accepted"); // RQ4

    property p_rq5;
        s_tok(TOK_IN) and (ctl[`BIT_TX_EP_EN] && ctl[`BIT_TX_STALL])
            |=> o_hs_code == ($past(setup_reg) ? HS_NAK : HS_STALL) && !o_tx_send;
    endproperty
    a_rq5: assert property (p_rq5) else $error("transmit stall answer wrong"); // RQ5

    property p_rq6;
        s_tok(TOK_SETUP) and !ctl[`BIT_CTL_EP] |=> o_hs_code == HS_SILENT && !o_rx_write;
    endproperty
    a_rq6: assert property (p_rq6) else $error("setup on non-control endpoint"); // RQ6

    property p_rq7;
        tok_v_reg && tok_ok_reg |=> o_rx_single_packet == $past(ctl[`BIT_RX_SINGLE]);
    endproperty
    a_rq7: assert property (p_rq7) else $error("single packet level wrong"); // RQ7

    property p_rq9;
        s_tok(TOK_OUT) and (ctl[`BIT_RX_EP_EN] && !ctl[`BIT_RX_STALL] && !ctl[`BIT_RX_IN_EN])
            |=> o_hs_code == HS_NAK && !o_rx_write;
    endproperty
    a_rq9: assert property (p_rq9) else $error("disabled input not refused"); // RQ9

    property p_rq10;
        s_tok(TOK_SETUP) and (ctl[`BIT_RX_EP_EN] && ctl[`BIT_CTL_EP] && !ctl[`BIT_RX_IN_EN])
            |=> o_rx_write;
    endproperty
    a_rq10: assert property (p_rq10) else $error("setup data not stored"); // RQ10

    property p_rq11;
        (mif.wr_en && idx_sel == `HUB_ENTRY) ##1 (i_rd && i_addr == `EPCTL_ADDR)
            |=> o_rdata[5:4] == 2'h3;
    endproperty
    a_rq11: assert property (p_rq11) else $error("hub fixed bits changed"); // RQ11

    property p_rq12;
        tok_v_reg && tok_ok_reg && tok_type_reg inside {TOK_OUT, TOK_SETUP}
            && !ctl[`BIT_RX_EP_EN] |=> o_hs_valid && o_hs_code == HS_SILENT && !o_rx_write;
    endproperty
    a_rq12: assert property (p_rq12) else $error("disabled receive answered"); // RQ12

    property p_rq13;
        s_tok(TOK_IN) and (ctl[1:0] == 2'h1 && !ctl[`BIT_TX_STALL]) |=> o_hs_code == HS_NAK;
    endproperty
    a_rq13: assert property (p_rq13) else $error("output disable not NAK"); // RQ13

    property p_rq14;
        s_tok(TOK_IN) and !ctl[`BIT_TX_EP_EN] |=> o_hs_code == HS_SILENT && !o_tx_send;
    endproperty
    a_rq14: assert property (p_rq14) else $error("disabled transmit answered"); // RQ14

    // A token for an index outside the table still gets a decision, always silence.
    property p_rq1_refuse;
        tok_v_reg && !tok_ok_reg
            |=> o_hs_valid && o_hs_code == HS_SILENT && !o_rx_write && !o_tx_send;
    endproperty
    a_rq1_refuse: assert property (p_rq1_refuse) else $error("unknown index answered"); // RQ1

    property p_rq7_hold;
        !(tok_v_reg && tok_ok_reg) |=> $stable(o_rx_single_packet);
    endproperty
    a_rq7_hold: assert property (p_rq7_hold) else $error("single packet level moved"); // RQ7

    property p_rq9_accept;
        s_tok(TOK_OUT) and (ctl[`BIT_RX_EP_EN] && !ctl[`BIT_RX_STALL] && ctl[`BIT_RX_IN_EN])
            |=> o_hs_code == HS_DATA && o_rx_write && !o_tx_send;
    endproperty
    a_rq9_accept: assert property (p_rq9_accept) else $error("enabled input refused"); // RQ9

    property p_rq11_hub;
        i_token_valid && i_token_ep == `HUB_INDEX |=> ctl[`BIT_CTL_EP] && ctl[`BIT_RX_SINGLE];
    endproperty
    a_rq11_hub: assert property (p_rq11_hub) else $error("hub fixed bits not one"); // RQ11

    property p_rq13_send;
        s_tok(TOK_IN) and (ctl[1:0] == 2'h3 && !ctl[`BIT_TX_STALL])
            |=> o_hs_code == HS_DATA && o_tx_send && !o_rx_write;
    endproperty
    a_rq13_send: assert property (p_rq13_send) else $error("enabled output not sent"); // RQ13

    c_refuse: cover property (o_hs_valid && o_hs_code == HS_SILENT && $past(!tok_ok_reg));
    c_setup: cover property (o_rx_write && $past(tok_type_reg) == TOK_SETUP);
    c_stall: cover property (o_hs_code == HS_STALL);
    c_nak_out: cover property (o_hs_code == HS_NAK && $past(tok_type_reg) == TOK_OUT);
    c_send: cover property (o_tx_send);

endmodule // usb_ep_ctrl

// *** verilog/usb_ep_map.svh ***
// Offsets, field positions and reset values of the endpoint control block.
// Included by the package, and its macros are then used by the design files; holds definitions only.
`ifndef USB_EP_MAP_SVH
`define USB_EP_MAP_SVH

`define EPCTL_ADDR 8'he1
`define EPIDX_ADDR 8'hf1
`define HSSTAT_ADDR 8'he2

`define BIT_RX_STALL 7
`define BIT_TX_STALL 6
`define BIT_CTL_EP 5
`define BIT_RX_SINGLE 4
`define BIT_RX_IN_EN 3
`define BIT_RX_EP_EN 2
`define BIT_TX_OUT_EN 1
`define BIT_TX_EP_EN 0

`define EP0_RST 8'h35
`define EPN_RST 8'h10
`define HUB_RST 8'h30
`define HUB_FIXED_MASK 8'h30
`define EPIDX_RST 8'h00

`define HUB_INDEX 8'h80
`define EP_ENTRIES 5
`define FUNC_EP_LAST 8'h03
`define HUB_ENTRY 3'h4
`define NO_ENTRY 3'h7

`endif

// *** verilog/usb_ep_pkg.sv ***
// Types and the index decode shared by the endpoint control design files.
// Assumes the map header is on the include path.
`include "usb_ep_map.svh"

package usb_ep_pkg;

    typedef enum logic [1:0] {
        TOK_NONE = 2'h0,
        TOK_OUT = 2'h1,
        TOK_IN = 2'h2,
        TOK_SETUP = 2'h3
    } token_t;

    typedef enum logic [1:0] {
        HS_SILENT = 2'h0,
        HS_DATA = 2'h1,
        HS_NAK = 2'h2,
        HS_STALL = 2'h3
    } hs_t;

    // Endpoints 0..3 and the hub endpoint share one small table; any other
    // index selects nothing.
    function automatic logic [2:0] entry_of(input logic [7:0] index);
        logic [2:0] sel;
        sel = `NO_ENTRY;
        if (index <= `FUNC_EP_LAST) begin
            sel = index[2:0];
        end else if (index == `HUB_INDEX) begin
            sel = `HUB_ENTRY;
        end
        return sel;
    endfunction

endpackage
